// File: rtl/cgc_map.svh
// Constants of the clock generator control block: field widths, counts, limits.
// Assumes inclusion by cgc_pkg and cgc_clock_ctrl only.
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

`define CGC_STARTUP_W     8
`define CGC_DIV_W         8
`define CGC_MUL_W         11
`define CGC_LOCK_W        6
`define CGC_FREQ_W        16
`define CGC_CREDIT_W      16
`define CGC_PRESCALE_W    3
`define CGC_PRESCALE_LAST 3'h7
`define CGC_MEAS_PERIODS  4'hf
`define CGC_CREDIT_CAP    16'hf000
`define CGC_IRQ_W         2
`define CGC_IRQ_STABLE    0
`define CGC_IRQ_LOCKED    1
`define CGC_SEL_SLOW      1'h0

`endif

// File: rtl/cgc_pkg.sv
// Types of the clock generator control block.
// Assumes cgc_map.svh on the include path.
`default_nettype none
`include "cgc_map.svh"

package cgc_pkg;

  typedef struct packed {
    logic                       enable;
    logic                       bypass;
    logic [`CGC_STARTUP_W-1:0]  startup;
  } cgc_osc_cfg_t;

  typedef struct packed {
    logic [`CGC_DIV_W-1:0]   div;
    logic [`CGC_MUL_W-1:0]   mul;
    logic [`CGC_LOCK_W-1:0]  lock_wait;
  } cgc_synth_cfg_t;

  typedef enum logic [1:0] {
    FM_IDLE,
    FM_WAIT,
    FM_COUNT,
    FM_DONE
  } cgc_meas_t;

  typedef struct packed {
    logic                        always_on_clock_q;
    logic                        mck_q;
    cgc_osc_cfg_t                osc;
    logic                        osc_run;
    logic [`CGC_PRESCALE_W-1:0]  pre;
    logic [`CGC_STARTUP_W-1:0]   osc_cnt;
    logic                        stable;
    cgc_meas_t                   meas;
    logic [3:0]                  periods;
    logic [`CGC_FREQ_W-1:0]      freq;
    logic                        done;
    cgc_synth_cfg_t              syn;
    logic                        lock_run;
    logic [`CGC_LOCK_W-1:0]      lock_cnt;
    logic                        locked;
    logic                        syn_en;
    logic [`CGC_CREDIT_W-1:0]    div_credit;
    logic [`CGC_CREDIT_W-1:0]    syn_credit;
    logic                        div_clk;
    logic                        syn_clk;
    logic                        always_on_clock_out;
    logic                        irq;
  } cgc_state_t;

endpackage

`default_nettype wire

// File: rtl/cgc_clock_ctrl.sv
// Clock generator control: oscillator start-up, frequency meter, divider and synthesiser lock.
// Assumes slow and crystal clocks arrive as inputs synchronous to mclk_i, well below its rate.
`default_nettype none
`include "cgc_map.svh"

module cgc_clock_ctrl (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      always_on_clock_i,
  input  wire logic                      crystal_osc_clock_i,
  input  wire logic                      osc_ctrl_wr_i,
  input  wire cgc_pkg::cgc_osc_cfg_t     osc_ctrl_i,
  input  wire logic                      synth_cfg_wr_i,
  input  wire cgc_pkg::cgc_synth_cfg_t   synth_cfg_i,
  input  wire logic [`CGC_IRQ_W-1:0]     irq_mask_i,
  output logic                           osc_enable_o,
  output logic                           osc_bypass_o,
  output logic                           sys_clock_sel_o,
  output logic                           osc_stable_flag_o,
  output logic                           freq_measure_done_o,
  output logic [`CGC_FREQ_W-1:0]         freq_measure_value_o,
  output logic [`CGC_DIV_W-1:0]          input_divider_value_o,
  output logic [`CGC_MUL_W-1:0]          multiplier_value_o,
  output logic                           synth_enable_o,
  output logic                           synth_locked_flag_o,
  output logic                           div_clock_o,
  output logic                           synth_clock_o,
  output logic                           always_on_clock_o,
  output logic                           irq_o
);
  import cgc_pkg::*;

  // ************************************************************
  // Credit-based rate generator
  // ************************************************************
  // Each source edge adds credit; each whole divisor spent toggles the output.
  // Output rate is bounded by mclk/2, so high ratios saturate instead of aliasing.
  function automatic logic [`CGC_CREDIT_W:0] nco_step(
    input logic [`CGC_CREDIT_W-1:0] credit,
    input logic [`CGC_CREDIT_W-1:0] add,
    input logic [`CGC_DIV_W-1:0]    div
  );
    logic [`CGC_CREDIT_W:0]   sum;
    logic                     tog;
    sum = {1'b0, credit} + {1'b0, add};
    tog = 1'b0;
    if (sum >= {{(`CGC_CREDIT_W-`CGC_DIV_W+1){1'b0}}, div}) begin
      sum = sum - {{(`CGC_CREDIT_W-`CGC_DIV_W+1){1'b0}}, div};
      tog = 1'b1;
    end
    if (sum > {1'b0, `CGC_CREDIT_CAP}) begin
      sum = {1'b0, `CGC_CREDIT_CAP};
    end
    return {tog, sum[`CGC_CREDIT_W-1:0]};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  cgc_state_t st_r;
  cgc_state_t st_nxt;

  logic                      always_on_clock_rise;
  logic                      always_on_clock_fall;
  logic                      mck_rise;
  logic                      syn_change;
  logic [`CGC_CREDIT_W:0]    div_step;
  logic [`CGC_CREDIT_W:0]    syn_step;
  logic [`CGC_CREDIT_W-1:0]  syn_add;

  assign always_on_clock_rise  = always_on_clock_i & ~st_r.always_on_clock_q;
  assign always_on_clock_fall  = ~always_on_clock_i & st_r.always_on_clock_q;
  assign mck_rise   = crystal_osc_clock_i & ~st_r.mck_q & (st_r.osc.enable | st_r.osc.bypass);
  assign syn_change = synth_cfg_wr_i
                      & ((synth_cfg_i != st_r.syn)
                         | ((st_r.syn.mul == '0) & (synth_cfg_i.mul != '0)));
  assign syn_add    = {{(`CGC_CREDIT_W-`CGC_MUL_W-1){1'b0}}, st_r.syn.mul, 1'b0}
                      + `CGC_CREDIT_W'(2);
  assign div_step   = nco_step(st_r.div_credit, mck_rise ? `CGC_CREDIT_W'(2) : '0,
                               st_r.syn.div);
  assign syn_step   = nco_step(st_r.syn_credit, mck_rise ? syn_add : '0, st_r.syn.div);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.always_on_clock_q   = always_on_clock_i;
    st_nxt.mck_q    = crystal_osc_clock_i;
    st_nxt.always_on_clock_out = always_on_clock_i;

    // ************************************************************
    // Main oscillator start-up
    // ************************************************************
    if (osc_ctrl_wr_i) begin
      st_nxt.osc    = osc_ctrl_i;
      st_nxt.stable = 1'b0;
      st_nxt.osc_run = osc_ctrl_i.enable;
      st_nxt.osc_cnt = osc_ctrl_i.startup;
      st_nxt.pre     = '0;
    end else if (st_r.osc_run && always_on_clock_rise) begin
      st_nxt.pre = st_r.pre + `CGC_PRESCALE_W'(1);
      if (st_r.pre == `CGC_PRESCALE_LAST) begin
        if (st_r.osc_cnt <= `CGC_STARTUP_W'(1)) begin
          st_nxt.osc_cnt = '0;
          st_nxt.stable  = 1'b1;
          st_nxt.osc_run = 1'b0;
        end else begin
          st_nxt.osc_cnt = st_r.osc_cnt - `CGC_STARTUP_W'(1);
        end
      end
    end

    // ************************************************************
    // Frequency meter
    // ************************************************************
    case (st_r.meas)
      FM_IDLE: begin
        if (st_r.stable) begin
          st_nxt.meas = FM_WAIT;
        end
      end
      FM_WAIT: begin
        if (always_on_clock_rise) begin
          st_nxt.meas    = FM_COUNT;
          st_nxt.freq    = '0;
          st_nxt.periods = '0;
        end
      end
      FM_COUNT: begin
        if (mck_rise && st_r.freq != '1) begin
          st_nxt.freq = st_r.freq + `CGC_FREQ_W'(1);
        end
        if (always_on_clock_fall) begin
          st_nxt.periods = st_r.periods + 4'h1;
          if (st_r.periods == `CGC_MEAS_PERIODS) begin
            st_nxt.meas = FM_DONE;
            st_nxt.done = 1'b1;
          end
        end
      end
      FM_DONE: begin
      end
      default: begin
        st_nxt.meas = FM_IDLE;
      end
    endcase
    // A fresh start-up discards any old measurement
    if (!st_nxt.stable) begin
      st_nxt.meas = FM_IDLE;
      st_nxt.done = 1'b0;
    end

    // ************************************************************
    // Divider and synthesiser lock
    // ************************************************************
    if (synth_cfg_wr_i) begin
      st_nxt.syn = synth_cfg_i;
    end
    st_nxt.syn_en = (st_nxt.syn.mul != '0);
    if (syn_change) begin
      st_nxt.locked   = 1'b0;
      st_nxt.lock_cnt = synth_cfg_i.lock_wait;
      st_nxt.lock_run = (synth_cfg_i.mul != '0);
    end else if (st_r.lock_run && always_on_clock_rise) begin
      if (st_r.lock_cnt == '0) begin
        st_nxt.locked   = 1'b1;
        st_nxt.lock_run = 1'b0;
      end else begin
        st_nxt.lock_cnt = st_r.lock_cnt - `CGC_LOCK_W'(1);
      end
    end

    // Clocks only advance on the settings already in force; a write restarts them.
    if (st_r.syn.div == '0 || synth_cfg_wr_i) begin
      st_nxt.div_credit = '0;
      st_nxt.div_clk    = 1'b0;
    end else begin
      st_nxt.div_credit = div_step[`CGC_CREDIT_W-1:0];
      st_nxt.div_clk    = st_r.div_clk ^ div_step[`CGC_CREDIT_W];
    end
    if (st_r.syn.div == '0 || st_r.syn.mul == '0 || synth_cfg_wr_i) begin
      st_nxt.syn_credit = '0;
      st_nxt.syn_clk    = 1'b0;
    end else begin
      st_nxt.syn_credit = syn_step[`CGC_CREDIT_W-1:0];
      st_nxt.syn_clk    = st_r.syn_clk ^ syn_step[`CGC_CREDIT_W];
    end

    st_nxt.irq = |({st_nxt.locked, st_nxt.stable} & irq_mask_i);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    osc_enable_o          = st_r.osc.enable;
    osc_bypass_o          = st_r.osc.bypass;
    sys_clock_sel_o       = `CGC_SEL_SLOW;
    osc_stable_flag_o     = st_r.stable;
    freq_measure_done_o   = st_r.done;
    freq_measure_value_o  = st_r.freq;
    input_divider_value_o = st_r.syn.div;
    multiplier_value_o    = st_r.syn.mul;
    synth_enable_o        = st_r.syn_en;
    synth_locked_flag_o   = st_r.locked;
    div_clock_o           = st_r.div_clk;
    synth_clock_o         = st_r.syn_clk;
    always_on_clock_o     = st_r.always_on_clock_out;
    irq_o                 = st_r.irq;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_osc_enable_wr;
    osc_ctrl_wr_i && osc_ctrl_i.enable;
  endsequence

  sequence s_lock_final_tick;
    st_r.lock_run && always_on_clock_rise && st_r.lock_cnt == '0 && !syn_change;
  endsequence

  a_osc_en_cause: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(osc_enable_o) |-> $past(osc_ctrl_wr_i && osc_ctrl_i.enable))
    else $error("oscillator enabled without a write");

  a_disable_clears: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    osc_ctrl_wr_i && !osc_ctrl_i.enable |=> !osc_stable_flag_o && !osc_enable_o)
    else $error("stable flag survived oscillator disable");

  a_enable_loads: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_osc_enable_wr |=> !osc_stable_flag_o && st_r.osc_cnt == $past(osc_ctrl_i.startup)
                        && st_r.pre == '0)
    else $error("start-up countdown not loaded");

  a_stable_cause: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(osc_stable_flag_o) |-> $past(st_r.osc_run && always_on_clock_rise && st_r.pre == 3'h7
                                       && st_r.osc_cnt <= 8'h01))
    else $error("stable flag set before countdown end");

  a_done_holds: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    freq_measure_done_o && $past(freq_measure_done_o) |-> $stable(freq_measure_value_o))
    else $error("frequency value moved after done");

  a_div_zero_low: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    input_divider_value_o == '0 |=> !div_clock_o && !synth_clock_o)
    else $error("clock output active with divider zero");

  a_mul_zero_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    multiplier_value_o == '0 |-> !synth_enable_o && !synth_locked_flag_o ##1 !synth_clock_o)
    else $error("synthesiser active with multiplier zero");

  a_change_unlocks: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    syn_change |=> !synth_locked_flag_o)
    else $error("lock flag kept over reconfiguration");

  a_lock_set: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_lock_final_tick |=> synth_locked_flag_o)
    else $error("lock flag not set at countdown end");

  a_irq_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 irq_o == |({synth_locked_flag_o, osc_stable_flag_o} & $past(irq_mask_i)))
    else $error("interrupt does not follow masked flags");

  a_osc_loads: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    osc_ctrl_wr_i |=> osc_enable_o == $past(osc_ctrl_i.enable)
                      && osc_bypass_o == $past(osc_ctrl_i.bypass))
    else $error("oscillator control bits not stored");

  a_count_decr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.osc_run && always_on_clock_rise && st_r.pre == 3'h7 && st_r.osc_cnt > 8'h01 && !osc_ctrl_wr_i
    |=> st_r.osc_cnt == $past(st_r.osc_cnt) - 8'h01)
    else $error("start-up count missed a divided tick");

  a_count_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.osc_run && !always_on_clock_rise && !osc_ctrl_wr_i
    |=> $stable(st_r.osc_cnt) && $stable(st_r.pre))
    else $error("start-up count moved without a slow edge");

  a_meas_wait: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.meas == FM_WAIT && !always_on_clock_rise |=> $stable(freq_measure_value_o))
    else $error("frequency counted before the slow clock rise");

  a_meas_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.meas == FM_WAIT && always_on_clock_rise && !osc_ctrl_wr_i
    |=> st_r.meas == FM_COUNT && freq_measure_value_o == '0)
    else $error("frequency count did not start at the slow clock rise");

  a_meas_step: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.meas == FM_COUNT && mck_rise && freq_measure_value_o != '1
    |=> freq_measure_value_o == $past(freq_measure_value_o) + 16'h0001)
    else $error("frequency count missed a main clock edge");

  a_meas_stop: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.meas == FM_COUNT && always_on_clock_fall && st_r.periods == 4'hf && !osc_ctrl_wr_i
    |=> freq_measure_done_o && st_r.meas == FM_DONE)
    else $error("measurement not done at sixteenth slow falling edge");

  a_done_cause: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(freq_measure_done_o) |-> $past(st_r.meas == FM_COUNT && always_on_clock_fall
                                         && st_r.periods == 4'hf))
    else $error("measurement done before sixteenth slow falling edge");

  a_div_loads: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    synth_cfg_wr_i |=> input_divider_value_o == $past(synth_cfg_i.div))
    else $error("divider value not stored");

  a_mul_loads: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    synth_cfg_wr_i |=> multiplier_value_o == $past(synth_cfg_i.mul))
    else $error("multiplier value not stored");

  a_lock_step: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.lock_run && always_on_clock_rise && st_r.lock_cnt != '0 && !syn_change
    |=> st_r.lock_cnt == $past(st_r.lock_cnt) - 6'h01 && !synth_locked_flag_o)
    else $error("lock countdown missed a slow clock tick");

  a_lock_cause: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(synth_locked_flag_o) |-> $past(st_r.lock_run && always_on_clock_rise && st_r.lock_cnt == '0))
    else $error("lock flag set before countdown end");

  a_slow_follows: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 always_on_clock_o == $past(always_on_clock_i))
    else $error("slow clock output gated or delayed");

endmodule

`default_nettype wire

// File: tb/cgc_clock_partner.sv
// Far-side model: slow and crystal clock sources, and a clock consumer counting rising edges.
// Assumes all of its signals are sampled on the rising edge of mclk_i.
`default_nettype none
module cgc_clock_partner #(
  parameter int SLOW_HALF = 4,
  parameter int XTAL_HALF = 2
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clr_i,
  input  wire logic        div_clock_i,
  input  wire logic        synth_clock_i,
  output logic             slow_o,
  output logic             xtal_o,
  output logic [15:0]      div_edges_o,
  output logic [15:0]      syn_edges_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   slow_cnt;
  int   xtal_cnt;
  logic div_q;
  logic syn_q;
  // Sources stay well under mclk/2 so every level is seen by the sampler
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slow_cnt <= 0;
      xtal_cnt <= 0;
      slow_o   <= 1'b0;
      xtal_o   <= 1'b0;
    end else begin
      slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
      xtal_cnt <= (xtal_cnt == XTAL_HALF - 1) ? 0 : xtal_cnt + 1;
      if (slow_cnt == SLOW_HALF - 1) slow_o <= ~slow_o;
      if (xtal_cnt == XTAL_HALF - 1) xtal_o <= ~xtal_o;
    end
  end
  // Consumer side: counts delivered clock edges for rate checks
  always_ff @(posedge mclk_i) begin
    div_q <= div_clock_i;
    syn_q <= synth_clock_i;
    if (clr_i) begin
      div_edges_o <= 16'h0;
      syn_edges_o <= 16'h0;
    end else begin
      if (div_clock_i && !div_q) div_edges_o <= div_edges_o + 16'h1;
      if (synth_clock_i && !syn_q) syn_edges_o <= syn_edges_o + 16'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_clock_generator_control.sv
// Self-checking bench for the clock generator control block.
// Assumes slow clock period of 8 mclk cycles and crystal period of 4 from the partner.
`default_nettype none
module test_clock_generator_control;
  timeunit 1ns;
  timeprecision 100ps;
  import cgc_pkg::*;
  logic             mclk_i;
  logic             reset_n_i;
  logic             osc_wr;
  cgc_osc_cfg_t     osc_cfg;
  logic             syn_wr;
  cgc_synth_cfg_t   syn_cfg;
  logic [1:0]       irq_mask;
  logic             clr;
  logic             slow;
  logic             xtal;
  logic [15:0]      div_edges;
  logic [15:0]      syn_edges;
  logic             osc_en;
  logic             osc_byp;
  logic             sel;
  logic             stable;
  logic             done;
  logic [15:0]      freq;
  logic [7:0]       div_v;
  logic [10:0]      mul_v;
  logic             syn_en;
  logic             locked;
  logic             div_clk;
  logic             syn_clk;
  logic             aon;
  logic             irq;
  int               n_errors;
  int               total_checks;
  int               n;
  logic             prev;

  cgc_clock_ctrl cgc_clock_ctrl_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .always_on_clock_i(slow),
    .crystal_osc_clock_i(xtal), .osc_ctrl_wr_i(osc_wr), .osc_ctrl_i(osc_cfg),
    .synth_cfg_wr_i(syn_wr), .synth_cfg_i(syn_cfg), .irq_mask_i(irq_mask),
    .osc_enable_o(osc_en), .osc_bypass_o(osc_byp), .sys_clock_sel_o(sel),
    .osc_stable_flag_o(stable), .freq_measure_done_o(done), .freq_measure_value_o(freq),
    .input_divider_value_o(div_v), .multiplier_value_o(mul_v), .synth_enable_o(syn_en),
    .synth_locked_flag_o(locked), .div_clock_o(div_clk), .synth_clock_o(syn_clk),
    .always_on_clock_o(aon), .irq_o(irq));

  cgc_clock_partner cgc_clock_partner_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clr_i(clr), .div_clock_i(div_clk),
    .synth_clock_i(syn_clk), .slow_o(slow), .xtal_o(xtal),
    .div_edges_o(div_edges), .syn_edges_o(syn_edges));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  // Returns one edge after the taking edge, so registered answers are settled
  task automatic osc_write(input logic en, input logic byp, input logic [7:0] st);
    osc_cfg = '{enable: en, bypass: byp, startup: st};
    osc_wr = 1'b1;
    cyc(1);
    osc_wr = 1'b0;
    cyc(1);
  endtask

  task automatic syn_write(input logic [7:0] d, input logic [10:0] m, input logic [5:0] lw);
    syn_cfg = '{div: d, mul: m, lock_wait: lw};
    syn_wr = 1'b1;
    cyc(1);
    syn_wr = 1'b0;
    cyc(1);
  endtask

  task automatic clear_counts;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // Whole run is under 2000 cycles; a generous bound cuts any hang
  initial begin
    repeat (6000) @(posedge mclk_i);
    n_errors++;
    finish_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    reset_n_i = 1'b0;
    osc_wr = 1'b0;
    syn_wr = 1'b0;
    osc_cfg = '0;
    syn_cfg = '0;
    irq_mask = 2'h0;
    clr = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 reset_n_i = 1'b1;
    cyc(1);
    check("osc_enable", osc_en, 1'b0);
    check("clock_sel", sel, 1'b0);
    check("divider", div_v, 8'h00);
    check("locked", locked, 1'b0);
    for (n = 0; n < 16; n++) begin
      prev = slow;
      cyc(1);
      check("always_on", aon, prev);
    end
    $display("test reset done");

    osc_write(1'b1, 1'b0, 8'h02);
    check("osc_enable", osc_en, 1'b1);
    check("stable_cleared", stable, 1'b0);
    cyc(110);
    check("stable_early", stable, 1'b0);
    for (n = 0; n < 30 && stable !== 1'b1; n++) cyc(1);
    check("stable_set", stable, 1'b1);
    check("irq_masked", irq, 1'b0);
    irq_mask = 2'h1;
    cyc(2);
    check("irq_stable", irq, 1'b1);
    for (n = 0; n < 160 && done !== 1'b1; n++) cyc(1);
    check("meas_done", done, 1'b1);
    check("meas_value", (freq >= 16'd31 && freq <= 16'd33), 1'b1);
    osc_write(1'b1, 1'b0, 8'h00);
    check("restart_clear", stable, 1'b0);
    check("done_clear", done, 1'b0);
    cyc(50);
    check("stable_min", stable, 1'b0);
    for (n = 0; n < 30 && stable !== 1'b1; n++) cyc(1);
    check("stable_min_set", stable, 1'b1);
    osc_write(1'b0, 1'b0, 8'h02);
    check("disable_clear", stable, 1'b0);
    check("irq_off", irq, 1'b0);
    $display("test oscillator done");

    osc_write(1'b0, 1'b1, 8'h00);
    check("bypass", osc_byp, 1'b1);
    check("osc_off", osc_en, 1'b0);
    syn_write(8'h00, 11'h003, 6'h02);
    clear_counts;
    cyc(40);
    check("div_zero_edges", div_edges, 16'h0);
    check("syn_zero_edges", syn_edges, 16'h0);
    irq_mask = 2'h2;
    syn_write(8'h04, 11'h001, 6'h02);
    check("lock_clear", locked, 1'b0);
    check("synth_on", syn_en, 1'b1);
    cyc(12);
    check("lock_early", locked, 1'b0);
    for (n = 0; n < 30 && locked !== 1'b1; n++) cyc(1);
    check("lock_set", locked, 1'b1);
    check("irq_lock", irq, 1'b1);
    clear_counts;
    cyc(160);
    check("div_rate", (div_edges >= 16'd9 && div_edges <= 16'd11), 1'b1);
    check("syn_rate", (syn_edges >= 16'd19 && syn_edges <= 16'd21), 1'b1);
    syn_write(8'hff, 11'h7ff, 6'h01);
    check("div_max", div_v, 8'hff);
    check("mul_max", mul_v, 11'h7ff);
    check("lock_clear2", locked, 1'b0);
    for (n = 0; n < 20 && locked !== 1'b1; n++) cyc(1);
    check("lock_set2", locked, 1'b1);
    syn_write(8'hff, 11'h000, 6'h00);
    check("synth_off", syn_en, 1'b0);
    clear_counts;
    cyc(20);
    check("synth_off_lock", locked, 1'b0);
    check("synth_off_edges", syn_edges, 16'h0);
    syn_write(8'h01, 11'h005, 6'h01);
    check("synth_reon", syn_en, 1'b1);
    check("reon_clear", locked, 1'b0);
    for (n = 0; n < 24 && locked !== 1'b1; n++) cyc(1);
    check("reon_lock", locked, 1'b1);
    $display("test synthesiser done");
    finish_test;
  end
endmodule
`default_nettype wire
